// >>> hdl/itm_pkg.sv
`default_nettype none
package itm_pkg;
   // ********************************************************
   // Register map (byte addresses on the APB)
   // ********************************************************
   localparam logic [7:0] OFS_COUNT_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CLOCK_PRESCALE = 8'h04;
   localparam logic [7:0] OFS_UP_COUNTER = 8'h08;
   localparam logic [7:0] OFS_COMPARE_VALUE = 8'h0C;

   // ********************************************************
   // Fields and reset values
   // ********************************************************
   localparam int unsigned BIT_COUNT_ENABLE = 7;
   localparam int unsigned BIT_WIDTH_SELECT = 4;
   localparam int unsigned SEL_LSB = 4;
   localparam logic [7:0] RST_COUNT_CONTROL = 8'h00;
   localparam logic [7:0] RST_CLOCK_PRESCALE = 8'h11;
   localparam logic [15:0] RST_UP_COUNTER = 16'h0000;

   // ********************************************************
   // Count clock selector
   // ********************************************************
   // Selector n (0..8) divides the clock by 8 << n, i.e. 8 .. 2048
   localparam logic [10:0] DIV_BASE = 11'h008;
   localparam logic [3:0] SEL_DIV_MAX = 4'h8;
   localparam logic [3:0] SEL_EDGE = 4'h9;

   typedef enum logic [3:0] {
      ITM_IDLE = 4'b0001,
      ITM_ARMED = 4'b0010,
      ITM_RUN = 4'b0100,
      ITM_HELD = 4'b1000
   } itm_phase_e;
endpackage
`default_nettype wire

// >>> hdl/itm_interval_timer.sv
// Register access over APB and the placing of the registers were left to the implementer.
`default_nettype none
module itm_interval_timer #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic count_edge_in,
   output logic compare_match_irq,
   output logic serial_clk_out
);
   // ********************************************************
   // Parameter check
   // ********************************************************
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 8 and 32");
   end

   // ********************************************************
   // State
   // ********************************************************
   typedef struct packed {
      logic [7:0] count_control;
      logic [7:0] clock_prescale;
      logic [15:0] up_counter;
      logic [10:0] divider;
      logic tick;
      logic edge_prev;
      itm_pkg::itm_phase_e phase;
      logic irq;
      logic sclk;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } itm_state_s;

   itm_state_s state_reg;
   itm_state_s state_next;
   logic [15:0] compare_value_reg;
   logic compare_we;
   logic [3:0] sel;
   logic [10:0] mask;
   logic [15:0] inc;
   logic hit;
   logic wide;
   logic upper_zero;
   logic mapped;
   logic wr_access;
   logic [7:0] offset;

   assign offset = paddr[7:0];
   assign upper_zero = ((paddr >> 8) == '0);
   assign mapped = upper_zero && (offset == itm_pkg::OFS_COUNT_CONTROL
                   || offset == itm_pkg::OFS_CLOCK_PRESCALE
                   || offset == itm_pkg::OFS_UP_COUNTER
                   || offset == itm_pkg::OFS_COMPARE_VALUE);
   // Write lands on the access edge that the slave answers with ready
   assign wr_access = psel && penable && pwrite && state_reg.ready && !state_reg.slverr;
   assign compare_we = wr_access && offset == itm_pkg::OFS_COMPARE_VALUE;

   // ********************************************************
   // Next state
   // ********************************************************
   always_comb begin
      state_next = state_reg;
      state_next.irq = 1'b0;
      state_next.ready = 1'b0;
      state_next.slverr = 1'b0;
      state_next.divider = state_reg.divider + 11'h001;
      state_next.edge_prev = count_edge_in;
      wide = state_reg.count_control[itm_pkg::BIT_WIDTH_SELECT];
      sel = state_reg.clock_prescale[itm_pkg::SEL_LSB +: 4];
      mask = 11'h000;

      // Free-running divider; a full low-bit pattern marks one count clock
      if (sel <= itm_pkg::SEL_DIV_MAX) begin
         mask = (itm_pkg::DIV_BASE << sel) - 11'h001;
         state_next.tick = ((state_reg.divider & mask) == mask);
      end else if (sel == itm_pkg::SEL_EDGE) begin
         state_next.tick = count_edge_in && !state_reg.edge_prev;
      end else begin
         state_next.tick = 1'b0;
      end

      // 8-bit mode wraps at 255 and ignores the upper compare byte
      inc = state_reg.up_counter + 16'h0001;
      if (!wide) begin
         inc[15:8] = 8'h00;
      end
      hit = wide ? (inc == compare_value_reg)
                 : (inc[7:0] == compare_value_reg[7:0]);

      if (state_reg.tick) begin
         case (state_reg.phase)
            itm_pkg::ITM_ARMED: begin
               state_next.up_counter = itm_pkg::RST_UP_COUNTER;
               state_next.phase = itm_pkg::ITM_RUN;
            end
            itm_pkg::ITM_RUN: begin
               state_next.up_counter = inc;
               // Only an increment can match, so compare writes never fire
               if (hit) begin
                  state_next.irq = 1'b1;
                  state_next.sclk = !state_reg.sclk;
                  state_next.phase = itm_pkg::ITM_HELD;
               end
            end
            itm_pkg::ITM_HELD: begin
               state_next.up_counter = itm_pkg::RST_UP_COUNTER;
               state_next.phase = itm_pkg::ITM_RUN;
            end
            itm_pkg::ITM_IDLE: begin
               state_next.phase = itm_pkg::ITM_IDLE;
            end
            default: begin
               state_next.phase = itm_pkg::ITM_IDLE;
               state_next.up_counter = itm_pkg::RST_UP_COUNTER;
            end
         endcase
      end

      // ********************************************************
      // APB: setup cycle fetches, access cycle completes
      // ********************************************************
      if (psel && !penable) begin
         state_next.ready = 1'b1;
         state_next.rdata = 32'h0000_0000;
         // Counter is read-only; a write to it is refused with an error
         state_next.slverr = !mapped
                             || (pwrite && offset == itm_pkg::OFS_UP_COUNTER);
         case (offset)
            itm_pkg::OFS_COUNT_CONTROL: begin
               state_next.rdata[7:0] = state_reg.count_control;
            end
            itm_pkg::OFS_CLOCK_PRESCALE: begin
               state_next.rdata[7:0] = state_reg.clock_prescale;
            end
            itm_pkg::OFS_UP_COUNTER: begin
               state_next.rdata[15:0] = state_reg.up_counter;
            end
            itm_pkg::OFS_COMPARE_VALUE: begin
               state_next.rdata[15:0] = compare_value_reg;
            end
            default: begin
               state_next.rdata = 32'h0000_0000;
            end
         endcase
         if (!upper_zero) begin
            state_next.rdata = 32'h0000_0000;
         end
      end

      if (wr_access) begin
         case (offset)
            itm_pkg::OFS_COUNT_CONTROL: begin
               state_next.count_control = pwdata[7:0];
               if (!pwdata[itm_pkg::BIT_COUNT_ENABLE]) begin
                  // Stop wins over a match in the same cycle
                  state_next.up_counter = itm_pkg::RST_UP_COUNTER;
                  state_next.phase = itm_pkg::ITM_IDLE;
                  state_next.irq = 1'b0;
                  state_next.sclk = state_reg.sclk;
               end else if (!state_reg.count_control[itm_pkg::BIT_COUNT_ENABLE]) begin
                  state_next.phase = itm_pkg::ITM_ARMED;
               end
               // Enable already set: phase untouched, counting goes on
            end
            itm_pkg::OFS_CLOCK_PRESCALE: begin
               state_next.clock_prescale = pwdata[7:0];
            end
            default: begin
               state_next.count_control = state_reg.count_control;
            end
         endcase
      end
   end

   // ********************************************************
   // Registers
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.count_control <= itm_pkg::RST_COUNT_CONTROL;
         state_reg.clock_prescale <= itm_pkg::RST_CLOCK_PRESCALE;
         state_reg.up_counter <= itm_pkg::RST_UP_COUNTER;
         state_reg.divider <= 11'h000;
         state_reg.tick <= 1'b0;
         state_reg.edge_prev <= 1'b0;
         state_reg.phase <= itm_pkg::ITM_IDLE;
         state_reg.irq <= 1'b0;
         state_reg.sclk <= 1'b0;
         state_reg.rdata <= 32'h0000_0000;
         state_reg.ready <= 1'b0;
         state_reg.slverr <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // No reset: software must load it before enabling the count
   always_ff @(posedge pclk) begin
      if (compare_we) begin
         compare_value_reg <= pwdata[15:0];
      end
   end

   assign prdata = state_reg.rdata;
   assign pready = state_reg.ready;
   assign pslverr = state_reg.slverr;
   assign compare_match_irq = state_reg.irq;
   assign serial_clk_out = state_reg.sclk;
endmodule
`default_nettype wire

// >>> verif/itm_checker.sv
`default_nettype none
module itm_checker #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic count_edge_in,
   input wire logic compare_match_irq,
   input wire logic serial_clk_out
);
   // Every offset sits below 16, so any higher bit or misalignment is unmapped
   logic bad;
   logic stop_wr;
   assign bad = (paddr[ADDR_W-1:4] != '0) || (paddr[1:0] != 2'h0);
   assign stop_wr = pready && pwrite && (paddr == '0) && !pwdata[7];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_answer; psel && !penable |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no answer after setup");
   property p_ready_one; pready |=> !pready; endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready held too long");
   property p_slverr; pready |-> pslverr == (bad || (pwrite && paddr == ADDR_W'(8))); endproperty
   a_slverr: assert property (p_slverr) else $error("error response wrong");
   property p_unmapped_zero; pready && !pwrite && bad |-> prdata == 32'h0; endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   property p_irq_pulse; compare_match_irq |=> !compare_match_irq [*3]; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("match pulse too wide");
   property p_stop_quiet; stop_wr |=> !compare_match_irq [*8]; endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("match after stop");
   property p_ser_follow; compare_match_irq |-> ##[0:1] $changed(serial_clk_out); endproperty
   a_ser_follow: assert property (p_ser_follow) else $error("serial clock missed match");
   property p_ser_cause;
      $changed(serial_clk_out) |-> compare_match_irq || $past(compare_match_irq);
   endproperty
   a_ser_cause: assert property (p_ser_cause) else $error("serial clock moved alone");
endmodule
bind itm_interval_timer itm_checker #(.ADDR_W(ADDR_W)) itm_checker_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .count_edge_in(count_edge_in), .compare_match_irq(compare_match_irq),
   .serial_clk_out(serial_clk_out));
`default_nettype wire

// >>> verif/itm_interval_timer_tb.sv
`default_nettype none
module itm_interval_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic count_edge_in = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic compare_match_irq;
   logic serial_clk_out;
   logic [31:0] rd;
   logic er;
   logic s0;
   int err_total = 0;
   int comparisons = 0;
   int irq_cnt = 0;
   int k;
   realtime t0;
   always #20 pclk = ~pclk;
   always @(negedge pclk) if (compare_match_irq === 1'b1) irq_cnt++;
   itm_interval_timer itm_interval_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_edge_in(count_edge_in),
      .compare_match_irq(compare_match_irq), .serial_clk_out(serial_clk_out));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Ready is read at the rising edge, before that edge's own updates land
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_total++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_irq(input int want);
      int n;
      n = 0;
      while (irq_cnt < want && n < 5000) begin
         @(negedge pclk);
         n++;
      end
      chk(32'(irq_cnt), 32'(want));
   endtask
   task automatic gap(input logic [31:0] exp);
      wait_irq(irq_cnt + 1);
      t0 = $realtime;
      wait_irq(irq_cnt + 1);
      chk(32'(int'(($realtime - t0) / 40.0)), exp);
   endtask
   task automatic pulse;
      @(posedge pclk);
      count_edge_in <= 1'b1;
      repeat (3) @(posedge pclk);
      count_edge_in <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h00);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h11);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_refuse;
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 12'h008, 32'h55);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_period;
      apb(1'b1, 12'h004, 32'h01);
      apb(1'b1, 12'h00C, 32'h2);
      apb(1'b1, 12'h000, 32'h80);
      k = irq_cnt + 1;
      wait_irq(k);
      t0 = $realtime;
      s0 = serial_clk_out;
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, 12'h000, 32'h80);
      wait_irq(k + 1);
      chk(32'(int'(($realtime - t0) / 40.0)), 32'h18);
      chk({31'h0, serial_clk_out}, {31'h0, ~s0});
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      k = irq_cnt;
      repeat (50) @(negedge pclk);
      chk(32'(irq_cnt), 32'(k));
   endtask
   task automatic t_wide;
      apb(1'b1, 12'h00C, 32'h0101);
      apb(1'b1, 12'h000, 32'h80);
      gap(32'h10);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h000, 32'h90);
      wait_irq(irq_cnt + 1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0101);
      apb(1'b1, 12'h000, 32'h0);
   endtask
   task automatic t_edge;
      apb(1'b1, 12'h004, 32'h91);
      apb(1'b1, 12'h00C, 32'h3);
      apb(1'b1, 12'h000, 32'h80);
      k = irq_cnt;
      repeat (3) pulse;
      chk(32'(irq_cnt), 32'(k));
      pulse;
      repeat (4) @(negedge pclk);
      chk(32'(irq_cnt), 32'(k + 1));
      apb(1'b1, 12'h000, 32'h0);
   endtask
   initial begin
      #(40ns * 20000);
      err_total++;
      wrap_up;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_refuse;
      t_period;
      t_wide;
      t_edge;
      wrap_up;
   end
endmodule
`default_nettype wire
